//--- design/tbpc_top.sv
`timescale 1ns/100ps
// Overview of operation
// RULE_01 - Software sets PWM pins as port outputs.
// RULE_02 - Cleared output enable releases the pin.
// RULE_03 - Each channel has 10-bit duty resolution.
// RULE_04 - One shared period, independent channel duties.
// RULE_05 - Postscaler never affects PWM output.
// RULE_06 - Outputs go active when time base clears.
// RULE_07 - Output clears when time base equals duty.
// RULE_08 - Duty at or above period gives 100%.
// RULE_09 - Duty registers double buffered, loaded at match.
// RULE_10 - Software writes both duty halves before match.
// RULE_11 - Polarity bit inverts the channel output.
// RULE_12 - Period is (period+1) times 4 times prescale.
// RULE_13 - After match: clear, set active, latch buffers.
// RULE_14 - Duty writes accepted anytime, effective at match.
// RULE_15 - Pulse width is duty times prescaled clock.
// RULE_16 - Duty ratio is duty over 4(period+1).
// RULE_17 - Two low time base bits count prescaled clocks.
// RULE_18 - Disabled channel holds output inactive.
// RULE_19 - Status bit shows output after polarity.
module tbpc_top (
    // Clock, reset and clock enable
    input  wire logic                              mclk,
    input  wire logic                              rstn,
    input  wire logic                              ce,
    // AXI4-Lite write address and data
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [tbpc_pkg::ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic [2:0]                        s_axi_awprot,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    input  wire logic [tbpc_pkg::DATA_W-1:0]       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    // AXI4-Lite write response
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    output logic [1:0]                             s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    input  wire logic [tbpc_pkg::ADDR_W-1:0]       s_axi_araddr,
    input  wire logic [2:0]                        s_axi_arprot,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    output logic [tbpc_pkg::DATA_W-1:0]            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    // PWM pins and update tick
    output logic [tbpc_pkg::NCH-1:0]               pwm_pin_o,
    output logic [tbpc_pkg::NCH-1:0]               pwm_pin_oe,
    output logic                                   update_tick
);
    tbpc_pkg::tbpc_bus_state_t wst_r;
    tbpc_pkg::tbpc_bus_state_t rst_r;
    logic [1:0]                         bresp_r;
    logic [1:0]                         rresp_r;
    logic [tbpc_pkg::DATA_W-1:0]        rdata_r;
    logic [tbpc_pkg::CNT_W-1:0]         period_r;
    logic [tbpc_pkg::TBC_W-1:0]         tbc_r;
    logic [tbpc_pkg::CNT_W-1:0]         tmr;
    logic [tbpc_pkg::NCH-1:0]           en_r;
    logic [tbpc_pkg::NCH-1:0]           oe_r;
    logic [tbpc_pkg::NCH-1:0]           pol_r;
    logic [tbpc_pkg::NCH-1:0]           out_state;
    logic [tbpc_pkg::CNT_W-1:0]         dch_r [tbpc_pkg::NCH];
    logic [tbpc_pkg::FRAC_W-1:0]        dcl_r [tbpc_pkg::NCH];
    logic [tbpc_pkg::NCH-1:0]           wh_ctrl;
    logic [tbpc_pkg::NCH-1:0]           wh_dch;
    logic [tbpc_pkg::NCH-1:0]           wh_dcl;
    logic [tbpc_pkg::NCH-1:0]           rh_any;
    logic [tbpc_pkg::REG_W-1:0]         rd_acc [tbpc_pkg::NCH+1];

    tbpc_tb_if tb ();

    // Write channel: address and data are taken together, one write at a time.
    wire [tbpc_pkg::ADDR_W-1:0] waddr    = s_axi_awaddr;
    wire [tbpc_pkg::REG_W-1:0]  wbyte    = s_axi_wdata[tbpc_pkg::REG_W-1:0];
    wire                        wr_go    = ce && s_axi_awvalid && s_axi_wvalid
                                           && (wst_r == tbpc_pkg::BUS_IDLE);
    wire                        wr_en    = wr_go && s_axi_wstrb[0];
    wire                        wh_per   = (waddr == tbpc_pkg::OFF_PERIOD);
    wire                        wh_cnt   = (waddr == tbpc_pkg::OFF_TB_COUNT);
    wire                        wh_tbc   = (waddr == tbpc_pkg::OFF_TB_CTRL);
    wire                        w_mapped = wh_per || wh_cnt || wh_tbc
                                           || (|wh_ctrl) || (|wh_dch) || (|wh_dcl);

    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    // Gated by ce so that a frozen block never completes a handshake twice.
    assign s_axi_bvalid  = ce && (wst_r == tbpc_pkg::BUS_RESP);
    assign s_axi_bresp   = bresp_r;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wst_r   <= tbpc_pkg::BUS_IDLE;
            bresp_r <= tbpc_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            case (wst_r)
                tbpc_pkg::BUS_IDLE:
                begin
                    if (wr_go)
                    begin
                        wst_r   <= tbpc_pkg::BUS_RESP;
                        bresp_r <= w_mapped ? tbpc_pkg::RESP_OKAY : tbpc_pkg::RESP_SLVERR;
                    end
                end
                tbpc_pkg::BUS_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        wst_r <= tbpc_pkg::BUS_IDLE;
                    end
                end
                default:
                begin
                    wst_r <= tbpc_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Shared period and time base control registers.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            period_r <= tbpc_pkg::PERIOD_RST;
            tbc_r    <= tbpc_pkg::TBC_RST;
        end
        else if (wr_en)
        begin
            if (wh_per)
            begin
                period_r <= wbyte; // RULE_04
            end
            if (wh_tbc)
            begin
                tbc_r <= wbyte[tbpc_pkg::TBC_W-1:0];
            end
        end
    end

    // Read channel.
    wire [tbpc_pkg::ADDR_W-1:0] raddr    = s_axi_araddr;
    wire                        rd_go    = ce && s_axi_arvalid && (rst_r == tbpc_pkg::BUS_IDLE);
    wire                        rh_per   = (raddr == tbpc_pkg::OFF_PERIOD);
    wire                        rh_cnt   = (raddr == tbpc_pkg::OFF_TB_COUNT);
    wire                        rh_tbc   = (raddr == tbpc_pkg::OFF_TB_CTRL);
    wire                        r_mapped = rh_per || rh_cnt || rh_tbc || (|rh_any);
    wire [tbpc_pkg::REG_W-1:0]  rd_glob  = rh_per ? period_r :
                                           rh_cnt ? tmr :
                                           rh_tbc ? {1'b0, tbc_r} : '0;
    wire [tbpc_pkg::REG_W-1:0]  rd_byte  = rd_glob | rd_acc[tbpc_pkg::NCH];

    assign s_axi_arready = rd_go;
    assign s_axi_rvalid  = ce && (rst_r == tbpc_pkg::BUS_RESP);
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign rd_acc[0]     = '0;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_r   <= tbpc_pkg::BUS_IDLE;
            rdata_r <= '0;
            rresp_r <= tbpc_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            case (rst_r)
                tbpc_pkg::BUS_IDLE:
                begin
                    if (rd_go)
                    begin
                        rst_r   <= tbpc_pkg::BUS_RESP;
                        rdata_r <= {{(tbpc_pkg::DATA_W-tbpc_pkg::REG_W){1'b0}}, rd_byte};
                        rresp_r <= r_mapped ? tbpc_pkg::RESP_OKAY : tbpc_pkg::RESP_SLVERR;
                    end
                end
                tbpc_pkg::BUS_RESP:
                begin
                    if (s_axi_rready)
                    begin
                        rst_r <= tbpc_pkg::BUS_IDLE;
                    end
                end
                default:
                begin
                    rst_r <= tbpc_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // The prescale and postscale fields only reach the time base, which owns the count.
    tbpc_timebase u_timebase (
        .mclk      (mclk),
        .rstn      (rstn),
        .ce        (ce),
        .run       (tbc_r[tbpc_pkg::TBC_RUN_BIT]),
        .presc_sel (tbc_r[tbpc_pkg::TBC_PS_LSB +: 2]),
        .post_sel  (tbc_r[tbpc_pkg::TBC_POST_LSB +: tbpc_pkg::POST_W]),
        .pr        (period_r),
        .cnt_wr    (wr_en && wh_cnt),
        .cnt_wdata (wbyte),
        .tb        (tb.src),
        .tmr       (tmr),
        .post_tick (update_tick)
    );

    genvar i;
    generate
        for (i = 0; i < tbpc_pkg::NCH; i++)
        begin : g_ch
            localparam logic [tbpc_pkg::ADDR_W-1:0] BASE =
                tbpc_pkg::ADDR_W'(tbpc_pkg::OFF_CH_BASE + i * tbpc_pkg::OFF_CH_STRIDE);
            wire                       rh_ctrl  = (raddr == BASE + tbpc_pkg::SUB_CTRL);
            wire                       rh_dch   = (raddr == BASE + tbpc_pkg::SUB_DUTY_HI);
            wire                       rh_dcl   = (raddr == BASE + tbpc_pkg::SUB_DUTY_LO);
            wire [tbpc_pkg::REG_W-1:0] ctrl_rd  =
                tbpc_pkg::REG_W'({en_r[i], oe_r[i], out_state[i], pol_r[i]})
                << tbpc_pkg::CTL_POL_BIT;
            wire [tbpc_pkg::REG_W-1:0] dcl_rd   =
                tbpc_pkg::REG_W'(dcl_r[i]) << tbpc_pkg::DCL_LSB;
            wire [tbpc_pkg::REG_W-1:0] ch_rd    = rh_ctrl ? ctrl_rd :
                                                  rh_dch  ? dch_r[i] :
                                                  rh_dcl  ? dcl_rd : '0;

            assign wh_ctrl[i]  = (waddr == BASE + tbpc_pkg::SUB_CTRL);
            assign wh_dch[i]   = (waddr == BASE + tbpc_pkg::SUB_DUTY_HI);
            assign wh_dcl[i]   = (waddr == BASE + tbpc_pkg::SUB_DUTY_LO);
            assign rh_any[i]   = rh_ctrl || rh_dch || rh_dcl;
            assign rd_acc[i+1] = rd_acc[i] | ch_rd;

            // Duty halves land here at any time; the channel copies them only at match.
            always_ff @(posedge mclk or negedge rstn)
            begin
                if (!rstn)
                begin
                    en_r[i]  <= 1'b0;
                    oe_r[i]  <= 1'b0;
                    pol_r[i] <= 1'b0;
                    dch_r[i] <= tbpc_pkg::DUTY_H_RST;
                    dcl_r[i] <= tbpc_pkg::DUTY_L_RST;
                end
                else if (wr_en)
                begin
                    if (wh_ctrl[i])
                    begin
                        en_r[i]  <= wbyte[tbpc_pkg::CTL_EN_BIT];
                        oe_r[i]  <= wbyte[tbpc_pkg::CTL_OE_BIT];
                        pol_r[i] <= wbyte[tbpc_pkg::CTL_POL_BIT];
                    end
                    if (wh_dch[i])
                    begin
                        dch_r[i] <= wbyte; // RULE_14
                    end
                    if (wh_dcl[i])
                    begin
                        dcl_r[i] <= wbyte[tbpc_pkg::DCL_LSB +: tbpc_pkg::FRAC_W]; // RULE_14
                    end
                end
            end

            tbpc_channel u_channel (
                .mclk      (mclk),
                .rstn      (rstn),
                .ce        (ce),
                .en        (en_r[i]),
                .oe        (oe_r[i]),
                .pol       (pol_r[i]),
                .duty_new  ({dch_r[i], dcl_r[i]}),
                .tb        (tb.snk),
                .pin_o     (pwm_pin_o[i]),
                .pin_oe    (pwm_pin_oe[i]),
                .out_state (out_state[i])
            );
        end
    endgenerate

    a_bresp_hold: assert property (@(posedge mclk) disable iff (!rstn)
        s_axi_bvalid && !s_axi_bready && ce |=> (wst_r == tbpc_pkg::BUS_RESP))
        else $error("write response dropped before acceptance");

    a_pin_release: assert property (@(posedge mclk) disable iff (!rstn) // RULE_02
        wr_en && (|wh_ctrl) && !wbyte[tbpc_pkg::CTL_OE_BIT] |=> ~|(pwm_pin_oe & $past(wh_ctrl)))
        else $error("pin still driven after output enable cleared");

endmodule

//--- design/tbpc_pkg.sv
package tbpc_pkg;

    localparam int NCH    = 4;
    localparam int CNT_W  = 8;
    localparam int FRAC_W = 2;
    localparam int DUTY_W = 10;
    localparam int DIV_W  = 6;
    localparam int POST_W = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;
    localparam int TBC_W  = 7;

    localparam logic [FRAC_W-1:0] FRAC_MAX = 2'h3;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_PERIOD    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_TB_COUNT  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_TB_CTRL   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CH_BASE   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CH_STRIDE = 8'h10;
    localparam logic [ADDR_W-1:0] SUB_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] SUB_DUTY_HI   = 8'h04;
    localparam logic [ADDR_W-1:0] SUB_DUTY_LO   = 8'h08;

    // Field positions.
    localparam int CTL_EN_BIT   = 7;
    localparam int CTL_OE_BIT   = 6;
    localparam int CTL_OUT_BIT  = 5;
    localparam int CTL_POL_BIT  = 4;
    localparam int DCL_LSB      = 6;
    localparam int TBC_PS_LSB   = 0;
    localparam int TBC_RUN_BIT  = 2;
    localparam int TBC_POST_LSB = 3;

    // Prescale select codes and the matching divider terminal counts.
    localparam logic [1:0]       PS_DIV1  = 2'h0;
    localparam logic [1:0]       PS_DIV4  = 2'h1;
    localparam logic [1:0]       PS_DIV16 = 2'h2;
    localparam logic [DIV_W-1:0] DMAX_1   = 6'h00;
    localparam logic [DIV_W-1:0] DMAX_4   = 6'h03;
    localparam logic [DIV_W-1:0] DMAX_16  = 6'h0F;
    localparam logic [DIV_W-1:0] DMAX_64  = 6'h3F;

    // Reset values.
    localparam logic [CNT_W-1:0]  PERIOD_RST = 8'hFF;
    localparam logic [TBC_W-1:0]  TBC_RST    = 7'h00;
    localparam logic [CNT_W-1:0]  DUTY_H_RST = 8'h00;
    localparam logic [FRAC_W-1:0] DUTY_L_RST = 2'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } tbpc_bus_state_t;

endpackage

//--- design/tbpc_tb_if.sv
`timescale 1ns/100ps
interface tbpc_tb_if;
    logic                            step;
    logic                            load;
    logic [tbpc_pkg::DUTY_W-1:0]     base_nxt;
    logic [tbpc_pkg::DUTY_W-1:0]     limit;
    modport src (output step, output load, output base_nxt, output limit);
    modport snk (input step, input load, input base_nxt, input limit);
endinterface

//--- design/tbpc_timebase.sv
`timescale 1ns/100ps
module tbpc_timebase (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rstn,
    input  wire logic                          ce,
    // Settings
    input  wire logic                          run,
    input  wire logic [1:0]                    presc_sel,
    input  wire logic [tbpc_pkg::POST_W-1:0]   post_sel,
    input  wire logic [tbpc_pkg::CNT_W-1:0]    pr,
    // Software write of the count
    input  wire logic                          cnt_wr,
    input  wire logic [tbpc_pkg::CNT_W-1:0]    cnt_wdata,
    // Time base
    tbpc_tb_if.src                             tb,
    output logic [tbpc_pkg::CNT_W-1:0]         tmr,
    output logic                               post_tick
);
    logic [tbpc_pkg::DIV_W-1:0]  div_r;
    logic [tbpc_pkg::FRAC_W-1:0] frac_r;
    logic [tbpc_pkg::CNT_W-1:0]  tmr_r;
    logic [tbpc_pkg::POST_W-1:0] post_r;
    logic                        post_tick_r;

    wire [tbpc_pkg::DIV_W-1:0]  div_max = (presc_sel == tbpc_pkg::PS_DIV1)  ? tbpc_pkg::DMAX_1  :
                                          (presc_sel == tbpc_pkg::PS_DIV4)  ? tbpc_pkg::DMAX_4  :
                                          (presc_sel == tbpc_pkg::PS_DIV16) ? tbpc_pkg::DMAX_16 :
                                          tbpc_pkg::DMAX_64;
    wire                        tick     = run && (div_r == div_max) && !cnt_wr; // RULE_17
    wire                        wrap     = (tmr_r == pr) && (frac_r == tbpc_pkg::FRAC_MAX);
    wire [tbpc_pkg::DUTY_W-1:0] base_inc = {tmr_r, frac_r} + 10'h001;
    wire [tbpc_pkg::DUTY_W-1:0] base_nxt = wrap ? '0 : base_inc; // RULE_13
    wire                        post_hit = (post_r == post_sel);

    assign tb.step     = ce && tick;
    assign tb.load     = wrap; // RULE_04
    assign tb.base_nxt = base_nxt;
    assign tb.limit    = {pr, tbpc_pkg::FRAC_MAX}; // RULE_16
    assign tmr         = tmr_r;
    assign post_tick   = post_tick_r;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_r  <= '0;
            frac_r <= '0;
            tmr_r  <= '0;
        end
        else if (ce && cnt_wr)
        begin
            tmr_r  <= cnt_wdata;
            frac_r <= '0;
            div_r  <= '0;
        end
        else if (ce && run)
        begin
            div_r <= tick ? '0 : div_r + 6'h01; // RULE_12
            if (tick)
            begin
                {tmr_r, frac_r} <= base_nxt; // RULE_17
            end
        end
    end

    // The postscaler only feeds the update tick, never the outputs.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            post_r      <= '0;
            post_tick_r <= 1'b0;
        end
        else if (ce)
        begin
            post_tick_r <= tick && wrap && post_hit; // RULE_05
            if (tick && wrap)
            begin
                post_r <= post_hit ? '0 : post_r + 4'h1;
            end
        end
    end

    a_period_wrap: assert property (@(posedge mclk) disable iff (!rstn) // RULE_13
        tb.step && wrap |=> (tmr_r == '0) && (frac_r == '0))
        else $error("time base did not clear after period match");

    a_presc_gap: assert property (@(posedge mclk) disable iff (!rstn) // RULE_12
        tb.step && (presc_sel == tbpc_pkg::PS_DIV4) |=> !tb.step [*3])
        else $error("prescale 1:4 step spacing too short");

endmodule

//--- design/tbpc_channel.sv
`timescale 1ns/100ps
module tbpc_channel (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rstn,
    input  wire logic                          ce,
    // Control
    input  wire logic                          en,
    input  wire logic                          oe,
    input  wire logic                          pol,
    input  wire logic [tbpc_pkg::DUTY_W-1:0]   duty_new,
    // Time base
    tbpc_tb_if.snk                             tb,
    // Pin and status
    output logic                               pin_o,
    output logic                               pin_oe,
    output logic                               out_state
);
    logic [tbpc_pkg::DUTY_W-1:0] buf_r;
    logic                        out_r;

    wire period_go = tb.step && tb.load;
    wire hit       = (tb.base_nxt == buf_r) && (buf_r <= tb.limit); // RULE_07 RULE_08 RULE_15
    wire out_nxt   = !en       ? 1'b0 :                              // RULE_18
                     period_go ? (duty_new != '0) :                  // RULE_06 RULE_13
                     (tb.step && hit) ? 1'b0 : out_r;                // RULE_07

    assign pin_o     = out_r ^ pol; // RULE_11
    assign pin_oe    = oe; // RULE_02
    assign out_state = out_r ^ pol; // RULE_19

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            buf_r <= '0;
            out_r <= 1'b0;
        end
        else if (ce)
        begin
            out_r <= out_nxt; // RULE_03
            if (period_go)
            begin
                buf_r <= duty_new; // RULE_09
            end
        end
    end

    a_start_active: assert property (@(posedge mclk) disable iff (!rstn) // RULE_06
        period_go && en && (duty_new != '0) |=> out_r)
        else $error("output not active at period start");

    a_zero_duty: assert property (@(posedge mclk) disable iff (!rstn) // RULE_13
        period_go && (duty_new == '0) |=> !out_r)
        else $error("zero duty output went active");

    a_match_clear: assert property (@(posedge mclk) disable iff (!rstn) // RULE_07
        tb.step && !tb.load && (tb.base_nxt == buf_r) && (buf_r <= tb.limit) |=> !out_r)
        else $error("output not cleared at duty match");

    a_full_duty: assert property (@(posedge mclk) disable iff (!rstn) // RULE_08
        ce && en && out_r && !tb.load && (buf_r > tb.limit) |=> out_r)
        else $error("full duty output was cleared");

    a_disabled_low: assert property (@(posedge mclk) disable iff (!rstn) // RULE_18
        ce && !en |=> !out_r)
        else $error("disabled channel output active");

    a_buffer_load: assert property (@(posedge mclk) disable iff (!rstn) // RULE_09
        period_go |=> buf_r == $past(duty_new))
        else $error("duty buffer not loaded at period match");

    a_buffer_hold: assert property (@(posedge mclk) disable iff (!rstn) // RULE_14
        !period_go |=> $stable(buf_r))
        else $error("duty buffer changed outside period match");

    a_pin_level: assert property (@(posedge mclk) disable iff (!rstn) // RULE_11
        pin_oe && (out_r == pol) |-> !pin_o)
        else $error("pin level does not follow polarity");

endmodule

//--- tb/tbpc_load.sv
`timescale 1ns/100ps
module tbpc_load (
    // Clock
    input  wire logic       mclk,
    // Pin drive from the block
    input  wire logic [3:0] drv,
    input  wire logic [3:0] oe,
    // Level seen by the load
    output logic      [3:0] lvl
);
    logic [3:0] last_r = 4'h0;
    always_ff @(posedge mclk)
    begin
        last_r <= (oe & drv) | (~oe & last_r);
    end
    // A released pin floats, so it shows the inverse of its last driven level.
    assign lvl = (oe & drv) | (~oe & ~last_r);
endmodule

//--- tb/tb_timer_based_pwm_channels.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_timer_based_pwm_channels;
    logic        mclk, rstn, ce, awv, wv, bry, arv, rry;
    logic [7:0]  awa, ara, wd;
    logic [31:0] q;
    logic [1:0]  r;
    wire         awr, wr, bv, arr, rv, ut;
    wire  [1:0]  br, rr;
    wire  [31:0] rd;
    wire  [3:0]  po, poe, lvl;
    int          miscompares = 0;
    int          checked = 0;
    tbpc_top uut (.mclk(mclk), .rstn(rstn), .ce(ce), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_wdata({24'h0, wd}), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .pwm_pin_o(po), .pwm_pin_oe(poe), .update_tick(ut));
    tbpc_load load (.mclk(mclk), .drv(po), .oe(poe), .lvl(lvl));
    task automatic wrap_up(input bit late);
        miscompares += late;
        if (miscompares == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge mclk);
        {awa, ara, wd} <= {a, a, d};
        {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
        for (n = 0; (w ? awr : arr) !== 1'b1 && n < 50; n++)
            @(negedge mclk);
        @(posedge mclk);
        {awv, wv, arv} <= 3'h0;
        for (n = n; (w ? bv : rv) !== 1'b1 && n < 99; n++)
            @(negedge mclk);
        q = rd;
        r = w ? br : rr;
        @(posedge mclk);
        {bry, rry} <= 2'h0;
        if (n >= 99)
            wrap_up(1'b1);
    endtask
    task automatic hold(input logic v, inout int c);
        for (int n = 0; lvl[0] === v; n++)
        begin
            @(negedge mclk);
            c++;
            if (n > 300)
                wrap_up(1'b1);
        end
    endtask
    task automatic measure(input logic act, input int hi_e, input int per_e);
        int hi;
        int per;
        hold(act, hi);
        hold(!act, hi);
        hi = 0;
        hold(act, hi);
        per = hi;
        hold(!act, per);
        `CHK("pulse", hi_e, hi)
        `CHK("period", per_e, per)
    endtask
    task automatic check_reset();
        xfer(1'b0, tbpc_pkg::OFF_PERIOD, 8'h00);
        `CHK("period_compare", 32'h000000FF, q)
        xfer(1'b0, 8'hFC, 8'h00);
        `CHK("rresp", tbpc_pkg::RESP_SLVERR, r)
        xfer(1'b1, 8'hF0, 8'h00);
        `CHK("bresp", tbpc_pkg::RESP_SLVERR, r)
    endtask
    task automatic check_wave();
        xfer(1'b1, 8'h00, 8'h03);
        xfer(1'b1, 8'h14, 8'h01);
        xfer(1'b1, 8'h18, 8'h80);
        xfer(1'b1, 8'h24, 8'h10);
        xfer(1'b1, 8'h10, 8'hC0);
        xfer(1'b1, 8'h20, 8'hC0);
        xfer(1'b1, 8'h30, 8'hC0);
        // A large postscale proves the period ignores it.
        xfer(1'b1, 8'h08, 8'h7C);
        measure(1'b1, 6, 16);
        `CHK("full_and_zero", 2'h1, lvl[2:1])
    endtask
    task automatic check_polarity();
        xfer(1'b1, 8'h10, 8'hD0);
        xfer(1'b1, 8'h14, 8'h02);
        xfer(1'b1, 8'h08, 8'h7D);
        measure(1'b0, 40, 64);
        xfer(1'b0, 8'h20, 8'h00);
        `CHK("ch1_status", 32'h000000E0, q)
    endtask
    task automatic check_release();
        xfer(1'b1, 8'h10, 8'h90);
        xfer(1'b1, 8'h30, 8'h50);
        repeat (3) @(negedge mclk);
        `CHK("pin_oe", 2'h2, poe[1:0])
        `CHK("disabled", 1'b1, lvl[2])
        for (int n = 0; ut !== 1'b1 && n < 1100; n++)
            @(negedge mclk);
        `CHK("update_tick", 1'b1, ut)
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial
    begin
        {rstn, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
        ce = 1'b1;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        check_reset();
        check_wave();
        check_polarity();
        check_release();
        wrap_up(1'b0);
    end
endmodule
